// ### ixmp_pkg.sv
package ixmp_pkg;

    // widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int OFS_W  = 7;

    // opcode fields
    localparam int          OPC_HI_MSB   = 15;
    localparam int          OPC_HI_LSB   = 8;
    localparam int          OPC_NIB_LSB  = 12;
    localparam int          OFS_MODE_BIT = 7;
    localparam logic [7:0]  MOVE_HI_CODE = 8'hEB;
    localparam logic [3:0]  MOVE_W2_NIB  = 4'hF;
    localparam logic [7:0]  PUSH_HI_CODE = 8'hFA;

    // reset values, indirect read value and decrement step
    localparam logic [ADDR_W-1:0] SFP_RESET   = 12'h000;
    localparam logic [DATA_W-1:0] DATA_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] INDIRECT_RD = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ONE    = 12'h001;

    // four phases per instruction cycle, one clock each
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_e;

    typedef enum logic [3:0] {
        EX_IDLE = 4'b0001,
        EX_SRC  = 4'b0010,
        EX_DST  = 4'b0100,
        EX_PUSH = 4'b1000
    } exec_e;

    // pointer plus offset, kept to the data space width
    function automatic logic [ADDR_W-1:0] index_addr(input logic [ADDR_W-1:0] base,
                                                     input logic [OFS_W-1:0]  ofs);
        logic [ADDR_W:0] sum;
        sum        = {1'b0, base} + {{(ADDR_W + 1 - OFS_W){1'b0}}, ofs};
        index_addr = sum[ADDR_W-1:0];
    endfunction : index_addr

    function automatic logic is_indirect(input logic [ADDR_W-1:0] a,
                                         input logic [ADDR_W-1:0] lo,
                                         input logic [ADDR_W-1:0] hi);
        is_indirect = (a >= lo) && (a <= hi);
    endfunction : is_indirect

endpackage : ixmp_pkg

// ### ixmp_decode.sv
`timescale 1ns/1ps
module ixmp_decode (
    // fetched word
    input  wire logic [15:0] word,
    input  wire logic        ext_enable,
    // decoded
    output logic             move_first,
    output logic             move_second,
    output logic             push_op,
    output logic [6:0]       offset,
    output logic [7:0]       literal
);
    wire logic [7:0] hi_byte;
    wire logic [3:0] hi_nib;

    assign hi_byte = word[ixmp_pkg::OPC_HI_MSB:ixmp_pkg::OPC_HI_LSB];
    assign hi_nib  = word[ixmp_pkg::OPC_HI_MSB:ixmp_pkg::OPC_NIB_LSB];

    // first move word and push recognised only with the extended set on; the second-word match is not gated
    assign move_first  = ext_enable && (hi_byte == ixmp_pkg::MOVE_HI_CODE)
                         && word[ixmp_pkg::OFS_MODE_BIT];
    assign move_second = hi_nib == ixmp_pkg::MOVE_W2_NIB;
    assign push_op     = ext_enable && (hi_byte == ixmp_pkg::PUSH_HI_CODE);
    assign offset      = word[ixmp_pkg::OFS_W-1:0];
    assign literal     = word[ixmp_pkg::DATA_W-1:0];
endmodule : ixmp_decode

// ### indexed_move_and_push_exec.sv
`timescale 1ns/1ps
// How it works
// - move decodes as word EB with bit7 set; the second (F) word is taken unchecked, 7-bit offsets.
// - move addresses are stack frame pointer plus each 7-bit offset.
// - both move addresses may fall anywhere in 000h..FFFh.
// - source in indirect register range reads as 00h.
// - destination in indirect register range: no write, instruction is a no-op.
// - move takes two cycles: read source in Q4, write destination in Q4.
// - push decodes as upper byte FA with literal low byte, one cycle.
// - push writes literal at the current stack frame pointer.
// - pointer decrements by one after the write, write uses old value.
// - both are recognised only while the extended set is enabled.
module indexed_move_and_push_exec #(
    parameter logic [11:0] IND_LO = 12'hFE0,
    parameter logic [11:0] IND_HI = 12'hFEF
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // fetch stream
    input  wire logic [15:0] instr_word,
    input  wire logic        ext_enable,
    output logic             claim,
    output logic [3:0]       phase,
    // stack frame pointer load from the core
    input  wire logic        sfp_load,
    input  wire logic [11:0] sfp_load_val,
    output logic [11:0]      stack_frame_pointer,
    // data memory
    output logic [11:0]      mem_addr,
    output logic             mem_rd,
    input  wire logic [7:0]  mem_rdata,
    output logic             mem_wr,
    output logic [7:0]       mem_wdata
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    ixmp_pkg::phase_e  phase_r;
    ixmp_pkg::phase_e  phase_nxt;
    ixmp_pkg::exec_e   exec_r;
    ixmp_pkg::exec_e   exec_nxt;
    logic [11:0]       sfp_r;
    logic [11:0]       sfp_nxt;
    logic [6:0]        ofs_r;
    logic [6:0]        ofs_nxt;
    logic [7:0]        data_r;
    logic [7:0]        data_nxt;
    logic [11:0]       addr_r;
    logic [11:0]       addr_nxt;
    logic              rd_r;
    logic              rd_nxt;
    logic              wr_r;
    logic              wr_nxt;
    logic              claim_r;
    logic              claim_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // decode

    logic        dec_move1;
    logic        dec_push;
    logic [6:0]  dec_ofs;
    logic [7:0]  dec_lit;

    ixmp_decode u_decode (
        .word        (instr_word),
        .ext_enable  (ext_enable),
        .move_first  (dec_move1),
        .move_second (),
        .push_op     (dec_push),
        .offset      (dec_ofs),
        .literal     (dec_lit)
    );

    wire logic        at_q1;
    wire logic        at_q3;
    wire logic        at_q4;
    wire logic [11:0] idx_addr;
    wire logic        idx_indirect;
    wire logic [11:0] sfp_dec;
    wire logic        take_any;
    wire logic        addr_indirect;
    wire logic [7:0]  src_data;
    wire logic [11:0] sfp_held;

    assign at_q1        = phase_r == ixmp_pkg::PH_Q1;
    assign at_q3        = phase_r == ixmp_pkg::PH_Q3;
    assign at_q4        = phase_r == ixmp_pkg::PH_Q4;
    // pointer plus offset, carry out dropped
    assign idx_addr     = ixmp_pkg::index_addr(sfp_r, ofs_r);
    assign idx_indirect = ixmp_pkg::is_indirect(idx_addr, IND_LO, IND_HI);
    assign sfp_dec      = sfp_r - ixmp_pkg::ADDR_ONE;
    assign take_any     = dec_move1 || dec_push;
    // tests the latched read address, so a pointer load in Q3 cannot split address and test
    assign addr_indirect = ixmp_pkg::is_indirect(addr_r, IND_LO, IND_HI);
    assign src_data     = addr_indirect ? ixmp_pkg::INDIRECT_RD : mem_rdata;
    // core load lands on any clock; only the push decrement overrides it
    assign sfp_held     = sfp_load ? sfp_load_val : sfp_r;

    ////////////////////////////////////////////////////////////////////////////////
    // phase ring

    always_comb begin
        unique case (phase_r)
            ixmp_pkg::PH_Q1: phase_nxt = ixmp_pkg::PH_Q2;
            ixmp_pkg::PH_Q2: phase_nxt = ixmp_pkg::PH_Q3;
            ixmp_pkg::PH_Q3: phase_nxt = ixmp_pkg::PH_Q4;
            ixmp_pkg::PH_Q4: phase_nxt = ixmp_pkg::PH_Q1;
            default:         phase_nxt = ixmp_pkg::PH_Q1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // execution sequence

    always_comb begin
        exec_nxt  = exec_r;
        ofs_nxt   = ofs_r;
        data_nxt  = data_r;
        addr_nxt  = addr_r;
        rd_nxt    = 1'b0;
        wr_nxt    = 1'b0;
        claim_nxt = claim_r;
        sfp_nxt   = sfp_held;
        unique case (exec_r)
            ixmp_pkg::EX_IDLE: begin
                if (at_q1) begin
                    claim_nxt = take_any;
                    if (dec_move1) begin
                        exec_nxt = ixmp_pkg::EX_SRC;
                        ofs_nxt  = dec_ofs;
                    end else if (dec_push) begin
                        exec_nxt = ixmp_pkg::EX_PUSH;
                        data_nxt = dec_lit;
                    end
                end
            end
            ixmp_pkg::EX_SRC: begin
                if (at_q3) begin
                    addr_nxt = idx_addr;
                    rd_nxt   = 1'b1;
                end
                if (at_q4) begin
                    // read strobe still goes out, indirect data is replaced
                    data_nxt = src_data;
                    exec_nxt = ixmp_pkg::EX_DST;
                end
            end
            ixmp_pkg::EX_DST: begin
                if (at_q1) begin
                    // a malformed second word is taken as the offset anyway
                    ofs_nxt = dec_ofs;
                end
                // an indirect target drops the strobe, claim still runs both cycles
                if (at_q3 && !idx_indirect) begin
                    addr_nxt = idx_addr;
                    wr_nxt   = 1'b1;
                end
                if (at_q4) begin
                    exec_nxt  = ixmp_pkg::EX_IDLE;
                    claim_nxt = 1'b0;
                end
            end
            ixmp_pkg::EX_PUSH: begin
                if (at_q3) begin
                    // pointer as it stood before the decrement
                    addr_nxt = sfp_r;
                    wr_nxt   = 1'b1;
                end
                if (at_q4) begin
                    // decrement after the write, overriding a same-cycle load
                    sfp_nxt   = sfp_dec;
                    exec_nxt  = ixmp_pkg::EX_IDLE;
                    claim_nxt = 1'b0;
                end
            end
            default: begin
                exec_nxt  = ixmp_pkg::EX_IDLE;
                claim_nxt = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_r <= ixmp_pkg::PH_Q1;
            exec_r  <= ixmp_pkg::EX_IDLE;
            sfp_r   <= ixmp_pkg::SFP_RESET;
            ofs_r   <= '0;
            data_r  <= ixmp_pkg::DATA_RESET;
            addr_r  <= ixmp_pkg::SFP_RESET;
            rd_r    <= 1'b0;
            wr_r    <= 1'b0;
            claim_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            exec_r  <= exec_nxt;
            sfp_r   <= sfp_nxt;
            ofs_r   <= ofs_nxt;
            data_r  <= data_nxt;
            addr_r  <= addr_nxt;
            rd_r    <= rd_nxt;
            wr_r    <= wr_nxt;
            claim_r <= claim_nxt;
        end
    end

    assign claim               = claim_r;
    assign phase               = phase_r;
    assign stack_frame_pointer = sfp_r;
    assign mem_addr            = addr_r;
    assign mem_rd              = rd_r;
    assign mem_wr              = wr_r;
    assign mem_wdata           = data_r;

endmodule : indexed_move_and_push_exec

// ### ixmp_asserts.sv
`timescale 1ns/1ps
module ixmp_asserts (
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // fetch stream
    input wire logic [15:0] instr_word,
    input wire logic        ext_enable,
    input wire logic        claim,
    input wire logic [3:0]  phase,
    // pointer and memory
    input wire logic [11:0] stack_frame_pointer,
    input wire logic [11:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [7:0]  mem_wdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire idle_q1 = phase == 4'h1 && !claim && ext_enable;
    sequence push_take;
        idle_q1 && instr_word[15:8] == 8'hFA;
    endsequence
    sequence move_take;
        idle_q1 && instr_word[15:7] == 9'h1D7;
    endsequence
    phase_rot_a: assert property (1'b1 |=> phase == {$past(phase[2:0]), $past(phase[3])})
        else $error("phase ring broken");
    push_claim_a: assert property (push_take |=> claim [*3] ##1 !claim)
        else $error("push length wrong");
    move_claim_a: assert property (move_take |=> claim [*7] ##1 !claim)
        else $error("move length wrong");
    push_write_a: assert property (push_take |-> ##3 mem_wr && mem_addr == $past(stack_frame_pointer, 3) && mem_wdata == $past(instr_word[7:0], 3))
        else $error("push write wrong");
    push_dec_a: assert property (push_take ##3 mem_wr |=> stack_frame_pointer == $past(mem_addr) - 12'h001)
        else $error("pointer not decremented");
    move_read_a: assert property (move_take |-> ##3 mem_rd && mem_addr == $past(stack_frame_pointer, 3) + {5'h00, $past(instr_word[6:0], 3)})
        else $error("source address wrong");
    no_ext_a: assert property (phase == 4'h1 && !claim && !ext_enable |=> !claim)
        else $error("claimed while disabled");
    strobe_q4_a: assert property ((mem_rd || mem_wr) |-> phase == 4'h8 && claim && !(mem_rd && mem_wr))
        else $error("strobe outside Q4");
endmodule : ixmp_asserts

bind indexed_move_and_push_exec ixmp_asserts i_ixmp_asserts (.clk(clk), .arst_n(arst_n),
    .instr_word(instr_word), .ext_enable(ext_enable), .claim(claim), .phase(phase),
    .stack_frame_pointer(stack_frame_pointer), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata));

// ### ixmp_mem_model.sv
`timescale 1ns/1ps
module ixmp_mem_model (
    // clock
    input wire logic        clk,
    // data memory port
    input wire logic [11:0] mem_addr,
    input wire logic        mem_rd,
    output logic     [7:0]  mem_rdata,
    input wire logic        mem_wr,
    input wire logic [7:0]  mem_wdata
);
    logic [7:0] mem [4096];
    initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 37 + 5);
    // unread port shows inverted data so a stray sample cannot match
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
    always @(posedge clk) if (mem_wr) mem[mem_addr] <= mem_wdata;
endmodule : ixmp_mem_model

// ### tb_indexed_move_and_push_exec.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_indexed_move_and_push_exec;
    localparam logic [11:0] LO = 12'hFE0;
    localparam logic [11:0] HI = 12'hFEF;
    logic        clk, arst_n, ext_enable, claim, sfp_load, mem_rd, mem_wr;
    logic [15:0] instr_word;
    logic [3:0]  phase;
    logic [11:0] sfp_load_val, stack_frame_pointer, mem_addr;
    logic [7:0]  mem_rdata, mem_wdata;
    int          fails, n_checks, ref_sfp;
    logic [31:0] seed = 32'h5906;
    logic [7:0]  ref_mem [4096];
    indexed_move_and_push_exec #(.IND_LO(LO), .IND_HI(HI)) i_indexed_move_and_push_exec (
        .clk(clk), .arst_n(arst_n), .instr_word(instr_word), .ext_enable(ext_enable),
        .claim(claim), .phase(phase), .sfp_load(sfp_load), .sfp_load_val(sfp_load_val),
        .stack_frame_pointer(stack_frame_pointer), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata));
    ixmp_mem_model i_ixmp_mem_model (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata));
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task finish_test();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    // word held through Q1 only; idle word from Q2 so it is never taken twice
    task issue(input logic [15:0] w, input logic en);
        while (phase !== 4'h1) @(negedge clk);
        instr_word = w;
        ext_enable = en;
        @(negedge clk);
        instr_word = {8'h00, 8'(rnd())};
        ext_enable = 1'b1;
        repeat (3) @(negedge clk);
    endtask : issue
    function automatic bit ind(input int a);
        return a >= LO && a <= HI;
    endfunction : ind
    ////////////////////////////////////////////////////////////
    initial begin
        #20000;
        fails++;
        finish_test();
    end
    initial begin
        int k, os, od, sa, da;
        logic [7:0] v;
        arst_n = 0;
        ext_enable = 1;
        sfp_load = 0;
        sfp_load_val = 12'h000;
        instr_word = 16'h0000;
        ref_sfp = 0;
        for (int i = 0; i < 4096; i++) ref_mem[i] = 8'(i * 37 + 5);
        repeat (16) @(negedge clk);
        arst_n = 1;
        for (int n = 0; n < 80; n++) begin
            // directed start: pointer FD8, indirect source, wrapped and indirect targets
            k = n == 0 ? 0 : n < 3 ? 2 : rnd() % 5;
            v = 8'(rnd());
            os = n == 1 ? 16 : n == 2 ? 0 : rnd() % 128;
            od = n == 1 ? 40 : n == 2 ? 12 : rnd() % 128;
            case (k)
                0: begin
                    @(negedge clk);
                    sfp_load_val = n % 4 == 0 ? 12'hFD8 : n % 4 == 1 ? 12'h000 :
                                   n % 4 == 2 ? 12'hFFF : 12'(rnd());
                    ref_sfp = sfp_load_val;
                    sfp_load = 1;
                    @(negedge clk);
                    sfp_load = 0;
                end
                1: begin
                    sa = ref_sfp;
                    while (phase !== 4'h1) @(negedge clk);
                    fork
                        issue({8'hFA, v}, 1'b1);
                        // odd pushes race a core load into Q4; the decrement must win
                        if (n % 2 == 1) begin
                            repeat (3) @(negedge clk);
                            sfp_load_val = 12'(rnd());
                            sfp_load = 1;
                            @(negedge clk);
                            sfp_load = 0;
                        end
                    join
                    ref_mem[sa] = v;
                    ref_sfp = (ref_sfp + 4095) % 4096;
                    `CHK(i_ixmp_mem_model.mem[sa], ref_mem[sa])
                    `CHK(stack_frame_pointer, 12'(ref_sfp))
                end
                2: begin
                    sa = (ref_sfp + os) % 4096;
                    da = (ref_sfp + od) % 4096;
                    issue({8'hEB, 1'b1, 7'(os)}, 1'b1);
                    issue({4'hF, 5'(rnd()), 7'(od)}, 1'b1);
                    if (!ind(da)) ref_mem[da] = ind(sa) ? 8'h00 : ref_mem[sa];
                    `CHK(i_ixmp_mem_model.mem[da], ref_mem[da])
                end
                default: begin
                    issue(k == 3 ? {8'hFA, v} : {8'hEB, 1'b0, 7'(os)}, k != 3);
                    `CHK(stack_frame_pointer, 12'(ref_sfp))
                    `CHK(i_ixmp_mem_model.mem[ref_sfp], ref_mem[ref_sfp])
                end
            endcase
        end
        finish_test();
    end
endmodule : tb_indexed_move_and_push_exec
